// ===== logic/i2cms_pkg.sv
package i2cms_pkg;

  localparam int CLK_NS = 25;
  localparam int BIT_NS = 10000;
  localparam int QTR_CYC = BIT_NS / (4 * CLK_NS);
  localparam logic [7:0] DIV_RST = 8'(QTR_CYC - 1);

  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_CMD = 3'h1;
  localparam logic [2:0] A_BUF = 3'h2;
  localparam logic [2:0] A_STAT = 3'h3;
  localparam logic [2:0] A_IST = 3'h4;
  localparam logic [2:0] A_IMASK = 3'h5;
  localparam logic [2:0] A_DIV = 3'h6;

  localparam int CTRL_EN = 4;
  localparam logic [3:0] MODE_MASTER = 4'h1;
  localparam logic [3:0] MODE_RST = 4'h0;

  localparam int CMD_START = 0;
  localparam int CMD_RSTART = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_RCV = 3;
  localparam int CMD_ACK = 4;
  localparam int CMD_ACKD = 5;

  localparam int ST_SDET = 0;
  localparam int ST_PDET = 1;
  localparam int ST_WRITE_COLLISION_FLAG = 2;
  localparam int ST_ACKS = 3;
  localparam int ST_BUSY = 4;

  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_BYTE = 2;
  localparam int EV_ACK = 3;
  localparam int EV_RSTART = 4;
  localparam int EV_W = 5;

  localparam logic [3:0] LAST_TX = 4'h8;
  localparam logic [3:0] LAST_RX = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RSTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } i2cms_st_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2cms_req_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } i2cms_sync_t;

  typedef struct packed {
    i2cms_st_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] cnt;
    logic [8:0] sh;
    logic [7:0] buf_r;
    logic [3:0] mode;
    logic en;
    logic [7:0] div;
    logic ackd;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    logic sdet;
    logic pdet;
    logic write_collision_flag;
    logic acks;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] imask;
    logic irq;
    logic lo;
  } i2cms_state_t;

endpackage

// ===== logic/i2cms_sync.sv
`timescale 1ns/100ps
module i2cms_sync (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] pins_in,
  output logic [1:0] pins_out
);
  import i2cms_pkg::*;

  i2cms_sync_t s;
  i2cms_sync_t n;

  always_comb begin
    n = s;
    n.s1 = pins_in;
    n.s2 = s.s1;
  end

  // Idle bus level is high, so the chain resets to released lines.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      s <= n;
    end
  end

  assign pins_out = s.s2;
endmodule

// ===== logic/i2cms_top.sv
// Function
// RQ1 - Software selects master mode, then enables.
// RQ2 - Hardware drives and releases SCL and SDA.
// RQ3 - Start/Stop detect bits cleared by reset/disable.
// RQ4 - Software takes bus on Stop or idle.
// RQ5 - Software sequences each operation from status bits.
// RQ6 - Generate Start, Repeated Start, Stop on request.
// RQ7 - Buffer write starts byte transmission.
// RQ8 - Receive byte, then send Acknowledge on request.
// RQ9 - Software waits; no queued operations.
// RQ10 - Busy buffer write discarded, collision flag set.
// RQ11 - Interrupt flag set by each bus event.
// RQ12 - Collision flag sticky, never blocks later writes.
`timescale 1ns/100ps
module i2cms_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire i2cms_pkg::i2cms_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  import i2cms_pkg::*;

  i2cms_state_t s;
  i2cms_state_t n;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic active;
  logic busy;
  logic stall;
  logic wc;
  logic [EV_W-1:0] evt;
  logic wr_buf;
  logic wr_cmd;

  i2cms_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pins_in({scl_in, sda_in}),
    .pins_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_comb begin
    n = s;
    evt = '0;
    wc = 1'b0;
    tick = (s.cnt == 8'h00);
    active = s.en && (s.mode == MODE_MASTER); // RQ1
    busy = (s.st != ST_IDLE);
    stall = (s.q == 2'h2) && !scl_s;
    wr_buf = reg_req_in.wr && (reg_req_in.addr == A_BUF);
    wr_cmd = reg_req_in.wr && (reg_req_in.addr == A_CMD);
    n.cnt = tick ? s.div : s.cnt - 8'h01;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    n.rdata = 8'h00;

    // Bus monitor: conditions are seen from any master on the wire.
    if (s.scl_p && scl_s && s.sda_p && !sda_s) begin
      n.sdet = 1'b1;
      n.pdet = 1'b0;
    end
    if (s.scl_p && scl_s && !s.sda_p && sda_s) begin
      n.sdet = 1'b0;
      n.pdet = 1'b1;
    end

    // Each bus step is four quarters; a slave holding SCL low stretches quarter two.
    if (tick && busy && !stall) begin
      n.q = s.q + 2'h1;
      unique case (s.st)
        ST_START: begin
          if (s.q == 2'h0) begin
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
          end
          if (s.q == 2'h2) n.sda_oe = 1'b1; // RQ6
          if (s.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.st = ST_IDLE;
            evt[EV_START] = 1'b1; // RQ11
          end
        end
        ST_RSTART: begin
          if (s.q == 2'h0) n.sda_oe = 1'b0;
          if (s.q == 2'h1) n.scl_oe = 1'b0;
          if (s.q == 2'h2) n.sda_oe = 1'b1; // RQ6
          if (s.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.st = ST_IDLE;
            evt[EV_RSTART] = 1'b1; // RQ11
          end
        end
        ST_STOP: begin
          if (s.q == 2'h0) n.sda_oe = 1'b1;
          if (s.q == 2'h1) n.scl_oe = 1'b0;
          if (s.q == 2'h3) begin
            n.sda_oe = 1'b0; // RQ6
            n.st = ST_IDLE;
            evt[EV_STOP] = 1'b1; // RQ11
          end
        end
        ST_TX: begin
          if (s.q == 2'h0) n.sda_oe = !s.sh[8]; // RQ7
          if (s.q == 2'h1) n.scl_oe = 1'b0; // RQ2
          if (s.q == 2'h2 && s.bitn == LAST_TX) n.acks = sda_s;
          if (s.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.sh = {s.sh[7:0], 1'b1};
            n.bitn = s.bitn + 4'h1;
            if (s.bitn == LAST_TX) begin
              n.st = ST_IDLE;
              evt[EV_BYTE] = 1'b1; // RQ11
            end
          end
        end
        ST_RX: begin
          if (s.q == 2'h0) n.sda_oe = 1'b0;
          if (s.q == 2'h1) n.scl_oe = 1'b0;
          if (s.q == 2'h2) n.sh = {s.sh[7:0], sda_s}; // RQ8
          if (s.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.bitn = s.bitn + 4'h1;
            if (s.bitn == LAST_RX) begin
              n.buf_r = s.sh[7:0];
              n.st = ST_IDLE;
              evt[EV_BYTE] = 1'b1; // RQ11
            end
          end
        end
        ST_ACK: begin
          if (s.q == 2'h0) n.sda_oe = !s.ackd; // RQ8
          if (s.q == 2'h1) n.scl_oe = 1'b0;
          if (s.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.st = ST_IDLE;
            evt[EV_ACK] = 1'b1; // RQ11
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end

    // Commands are only taken while idle; there is no queue behind the engine.
    if (wr_cmd && active && !busy) begin
      n.q = 2'h0;
      n.bitn = 4'h0;
      n.cnt = s.div;
      n.ackd = reg_req_in.wdata[CMD_ACKD];
      if (reg_req_in.wdata[CMD_START]) n.st = ST_START; // RQ6
      else if (reg_req_in.wdata[CMD_RSTART]) n.st = ST_RSTART;
      else if (reg_req_in.wdata[CMD_STOP]) n.st = ST_STOP;
      else if (reg_req_in.wdata[CMD_RCV]) n.st = ST_RX; // RQ8
      else if (reg_req_in.wdata[CMD_ACK]) n.st = ST_ACK;
    end

    if (wr_buf) begin
      if (active && busy) begin
        wc = 1'b1; // RQ10
      end else begin
        n.buf_r = reg_req_in.wdata;
        if (active) begin
          n.st = ST_TX; // RQ7
          n.sh = {reg_req_in.wdata, 1'b1};
          n.q = 2'h0;
          n.bitn = 4'h0;
          n.cnt = s.div;
        end
      end
    end

    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        A_CTRL: begin
          n.mode = reg_req_in.wdata[3:0];
          n.en = reg_req_in.wdata[CTRL_EN];
        end
        A_IMASK: n.imask = reg_req_in.wdata[EV_W-1:0];
        A_DIV: n.div = reg_req_in.wdata;
        default: n.lo = 1'b0;
      endcase
    end

    // Set wins over a clearing write in the same cycle.
    n.write_collision_flag = wc || (s.write_collision_flag && !(reg_req_in.wr && reg_req_in.addr == A_STAT
                                && reg_req_in.wdata[ST_WRITE_COLLISION_FLAG])); // RQ12
    n.ist = evt | (s.ist & ~((reg_req_in.wr && reg_req_in.addr == A_IST)
                              ? reg_req_in.wdata[EV_W-1:0] : '0));

    if (!active) begin
      n.st = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end
    if (!s.en) begin
      n.sdet = 1'b0; // RQ3
      n.pdet = 1'b0;
    end

    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        A_CTRL: n.rdata = {3'h0, s.en, s.mode};
        A_BUF: n.rdata = s.buf_r;
        A_STAT: n.rdata = {3'h0, busy, s.acks, s.write_collision_flag, s.pdet, s.sdet}; // RQ5
        A_IST: n.rdata = {3'h0, s.ist};
        A_IMASK: n.rdata = {3'h0, s.imask};
        A_DIV: n.rdata = s.div;
        default: n.rdata = 8'h00;
      endcase
    end

    n.irq = |(n.ist & n.imask); // RQ11
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{st: ST_IDLE, q: 2'h0, bitn: 4'h0, cnt: 8'h00, sh: 9'h000, buf_r: 8'h00,
             mode: MODE_RST, en: 1'b0, div: DIV_RST, ackd: 1'b0, rdata: 8'h00,
             scl_oe: 1'b0, sda_oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1, sdet: 1'b0,
             pdet: 1'b0, write_collision_flag: 1'b0, acks: 1'b0, ist: '0, imask: '0, irq: 1'b0,
             lo: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign scl_out = s.lo;
  assign sda_out = s.lo;
  assign scl_oe_out = s.scl_oe;
  assign sda_oe_out = s.sda_oe;
  assign irq_out = s.irq;

  sequence s_buf_wr;
    reg_req_in.wr && (reg_req_in.addr == A_BUF);
  endsequence

  sequence s_start_cmd;
    reg_req_in.wr && (reg_req_in.addr == A_CMD) && reg_req_in.wdata[CMD_START];
  endsequence

  property p_write_collision_flag;
    @(posedge clk_sys_in) disable iff (rst_in)
      (s_buf_wr ##0 (active && busy)) |=> (s.write_collision_flag && $stable(s.buf_r));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy buffer write not refused"); // RQ10

  property p_tx_go;
    @(posedge clk_sys_in) disable iff (rst_in)
      (s_buf_wr ##0 (active && !busy)) |=> (s.st == ST_TX && s.sh[8:1] == $past(reg_req_in.wdata));
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("buffer write did not start transmit"); // RQ7

  property p_det_clr;
    @(posedge clk_sys_in) disable iff (rst_in)
      !s.en |=> (!s.sdet && !s.pdet);
  endproperty
  a_det_clr: assert property (p_det_clr) else $error("detect bits set while disabled"); // RQ3

  property p_start_go;
    @(posedge clk_sys_in) disable iff (rst_in)
      (s_start_cmd ##0 (active && !busy)) |=> (s.st == ST_START && s.q == 2'h0);
  endproperty
  a_start_go: assert property (p_start_go) else $error("start request not taken"); // RQ6

  property p_sda_scl_low;
    @(posedge clk_sys_in) disable iff (rst_in)
      ((s.st == ST_TX || s.st == ST_RX) && $changed(s.sda_oe)) |-> s.scl_oe;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved while clock high"); // RQ2

  property p_release;
    @(posedge clk_sys_in) disable iff (rst_in)
      !active |=> (!s.scl_oe && !s.sda_oe && s.st == ST_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("lines driven outside master mode"); // RQ2

  property p_irq;
    @(posedge clk_sys_in) disable iff (rst_in)
      (|(evt & s.imask)) && !(reg_req_in.wr && reg_req_in.addr == A_IMASK) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event gave no interrupt"); // RQ11

  property p_rx_done;
    @(posedge clk_sys_in) disable iff (rst_in)
      (s.st == ST_RX && tick && !stall && s.q == 2'h3 && s.bitn == LAST_RX && active)
        |=> (s.ist[EV_BYTE] && s.st == ST_IDLE && s.buf_r == $past(s.sh[7:0]));
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("received byte not stored"); // RQ8

  property p_write_collision_flag_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      (s.write_collision_flag && !(reg_req_in.wr && reg_req_in.addr == A_STAT)) |=> s.write_collision_flag;
  endproperty
  a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision flag lost"); // RQ12
endmodule

// ===== bench/i2cms_slave.sv
`timescale 1ns/100ps
module i2cms_slave (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic pull_out
);
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic first;
  logic rd_mode;
  int bitn;
  initial begin
    pull_out = 1'b0;
    tx_byte = 8'h5C;
    bitn = 0;
    first = 1'b0;
    rd_mode = 1'b0;
  end
  // The slave only moves SDA while SCL is low, so an edge with SCL high is start or stop.
  always @(sda_in) begin
    if (scl_in === 1'b1) begin
      bitn = 0;
      first = !sda_in;
      rd_mode = 1'b0;
      pull_out = 1'b0;
    end
  end
  always @(posedge scl_in) begin
    if (bitn < 8) begin
      rx_byte = {rx_byte[6:0], sda_in};
      bitn = bitn + 1;
    end else begin
      bitn = 0;
      if (first) begin
        rd_mode = rx_byte[0];
      end else if (rd_mode && sda_in) begin
        rd_mode = 1'b0;
      end
      first = 1'b0;
    end
  end
  // A not-acknowledge from the master ends the read, so the line is let go for the stop.
  always @(negedge scl_in) begin
    if (bitn == 8) begin
      pull_out = !rd_mode || first;
    end else begin
      pull_out = rd_mode && !first && !tx_byte[7 - bitn];
    end
  end
endmodule

// ===== bench/i2cms_bench.sv
`timescale 1ns/100ps
module i2cms_bench;
  import i2cms_pkg::*;
  logic clk_sys_in;
  logic rst_in;
  i2cms_req_t req;
  logic [7:0] rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, pull;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int rises = 0;
  // Both lines have pull-ups: a released line reads high.
  wire scl_w = scl_oe ? scl_o : 1'b1;
  wire sda_w = (sda_oe ? sda_o : 1'b1) & !pull;

  i2cms_top DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .irq_out(irq));
  i2cms_slave u_slv (.scl_in(scl_w), .sda_in(sda_w), .pull_out(pull));

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = !clk_sys_in;
  end
  always @(posedge scl_w) rises++;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    req <= '0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    req <= '0;
    #1 d = rdata;
    @(posedge clk_sys_in);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, e, d & m);
  endtask
  task automatic wait_ev(input int b, input logic ei);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 100 && !d[b]; i++) rd(A_IST, d);
    chk("event", 8'(1 << b), d & 8'(1 << b));
    #1 chk("irq", {7'h0, ei}, {7'h0, irq});
    wr(A_IST, 8'(1 << b));
    #1 chk("irq clr", 8'h00, {7'h0, irq});
  endtask

  initial begin
    req = '0;
    rst_in = 1'b1;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk_reg("ctrl", A_CTRL, 8'hFF, 8'h00);
    chk_reg("stat", A_STAT, 8'hFF, 8'h00);
    chk_reg("div", A_DIV, 8'hFF, DIV_RST);
    chk_reg("unmapped", 3'h7, 8'hFF, 8'h00);
    #1 chk("oe", 8'h00, {6'h0, scl_oe, sda_oe});
    chk("drive lvl", 8'h00, {6'h0, scl_o, sda_o});
    $display("test reset done");
    wr(A_DIV, 8'h01);
    wr(A_BUF, 8'h33);
    wr(A_IMASK, 8'h01);
    wr(A_CTRL, {4'h0, MODE_MASTER});
    wr(A_CTRL, 8'h10 | {4'h0, MODE_MASTER});
    chk_reg("idle", A_STAT, 8'h03, 8'h00);
    wr(A_CMD, 8'h01);
    wr(A_BUF, 8'hA0);
    chk_reg("write_collision_flag", A_STAT, 8'h04, 8'h04);
    chk_reg("buf kept", A_BUF, 8'hFF, 8'h33);
    wait_ev(EV_START, 1'b1);
    chk_reg("start det", A_STAT, 8'h03, 8'h01);
    rises = 0;
    wr(A_BUF, 8'hA1);
    wait_ev(EV_BYTE, 1'b0);
    chk("scl rises", 8'h09, 8'(rises));
    chk_reg("ack in", A_STAT, 8'h0C, 8'h04);
    wr(A_STAT, 8'h04);
    chk_reg("write_collision_flag clr", A_STAT, 8'h04, 8'h00);
    wr(A_CMD, 8'h08);
    wait_ev(EV_BYTE, 1'b0);
    chk_reg("rx byte", A_BUF, 8'hFF, 8'h5C);
    // A driven acknowledge keeps the slave sending, so a second byte proves it reached the wire.
    wr(A_CMD, 8'h10);
    wait_ev(EV_ACK, 1'b0);
    wr(A_CMD, 8'h08);
    wait_ev(EV_BYTE, 1'b0);
    chk_reg("rx byte 2", A_BUF, 8'hFF, 8'h5C);
    wr(A_CMD, 8'h30);
    wait_ev(EV_ACK, 1'b0);
    $display("test read done");
    wr(A_CMD, 8'h02);
    wait_ev(EV_RSTART, 1'b0);
    wr(A_BUF, 8'hA0);
    wait_ev(EV_BYTE, 1'b0);
    wr(A_BUF, 8'h96);
    wait_ev(EV_BYTE, 1'b0);
    chk("wire byte", 8'h96, u_slv.rx_byte);
    chk_reg("ack in", A_STAT, 8'h08, 8'h00);
    wr(A_CMD, 8'h04);
    wait_ev(EV_STOP, 1'b0);
    // The detector sees the wire through a synchroniser, a few cycles behind.
    repeat (4) @(posedge clk_sys_in);
    chk_reg("stop det", A_STAT, 8'h03, 8'h02);
    wr(A_CTRL, {4'h0, MODE_MASTER});
    chk_reg("disabled", A_STAT, 8'h03, 8'h00);
    #1 chk("released", 8'h00, {6'h0, scl_oe, sda_oe});
    $display("test write done");
    print_verdict();
  end
endmodule
